// *** verilog/cfg_setup_pkg.sv ***
// constants and carrier types for the floppy and port setup registers
`default_nettype none
package cfg_setup_pkg;
	localparam logic [7:0] IDX_FLOPPY_IFACE = 8'h03;
	localparam logic [7:0] IDX_EXT_PORT     = 8'h04;
	localparam logic [7:0] RST_FLOPPY_IFACE = 8'h78;
	localparam logic [7:0] RST_EXT_PORT     = 8'h00;
	localparam logic [7:0] MASK_FLOPPY_IFACE = 8'hFE;
	localparam logic [7:0] MASK_EXT_PORT     = 8'h7F;
	// floppy setup fields
	localparam int FI_ENH_MODE  = 1;
	localparam int FI_PIN_SEL_L = 2;
	localparam int FI_OPT0      = 3;
	localparam int FI_OPT1      = 4;
	localparam int FI_ENC       = 5;
	localparam int FI_IDENT     = 6;
	localparam int FI_PIN_SEL_H = 7;
	// extended setup fields
	localparam int EP_MODE_LO  = 0;
	localparam int EP_FDC_LO   = 2;
	localparam int EP_UART_A   = 4;
	localparam int EP_UART_B   = 5;
	localparam int EP_EPP_TYPE = 6;
	// serial clock divisors and the ecr epp code
	localparam logic [3:0] DIV_NORMAL = 4'hD;
	localparam logic [3:0] DIV_MUSIC  = 4'hC;
	localparam logic [2:0] ECR_EPP_CODE = 3'h4;

	typedef enum logic [1:0] {PP_SPP, PP_EPP_SPP, PP_ECP, PP_ECP_EPP} pp_mode_t;
	typedef enum logic [1:0] {IF_RSVD, IF_ALT_B, IF_ALT_A, IF_AT} iface_mode_t;
	typedef enum logic [1:0] {PIN_DRV_IN, PIN_DECODE, PIN_IRQ2, PIN_RSVD} pin_role_t;

	typedef struct packed {
		logic        enh_mode;
		iface_mode_t iface_mode;
		pin_role_t   pin_role;
		pp_mode_t    pp_mode;
		logic [1:0]  pport_fdc;
		logic [3:0]  uart_a_div;
		logic [3:0]  uart_b_div;
		logic        epp_rev17;
		logic        ecr_epp_ok;
	} setup_cfg_t;
endpackage
`default_nettype wire

// *** verilog/fdc_pport_serial_setup_regs.sv ***
// floppy interface and extended port setup registers with rate pin mapping
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - floppy setup bit 0 reads zero
// - bit 1 selects normal or enhanced mode
// - drive option bits reset to one
// - enhanced mode ignores drive option bits
// - bits 6,5 select floppy interface mode
// - bits 7,2 select shared pin role
// - options 00: rate pins copy rate select
// - option0 only: remapped rate pin table
// - options 11: rate pins become inputs
// - 300 code may mean other rates
// - bits 3,2 route floppy through port
// - bit 4 picks uart a divisor
// - bit 5 picks uart b divisor
// - bit 6 picks epp revision
// - extended register at index 04H, reset 00H
// - floppy register at index 03H, reset 78H
// - divide by 12 gives music baud rate
// - ecp with epp allows ecr epp code
module fdc_pport_serial_setup_regs
	import cfg_setup_pkg::*;
(
	input  wire logic       clock,          // 200 MHz system clock
	input  wire logic       rst_n,          // synchronous reset, active low
	input  wire logic       config_mode,    // configuration mode active
	input  wire logic [7:0] config_index_reg, // loaded configuration index
	input  wire logic       wr_stb,         // data write pulse
	input  wire logic       rd_stb,         // data read pulse
	input  wire logic [7:0] wr_data,        // write data
	input  wire logic       printer_mode,   // port printer-mode bit
	input  wire logic [1:0] rate_sel,       // data-rate select code
	input  wire logic [1:0] rate_pin_in,    // rate pins sensed as inputs
	output logic      [7:0] rd_data,        // read data, registered
	output logic            rd_valid,       // read data valid pulse
	output logic            rate_pin_lo,    // rate pin 0 output
	output logic            rate_pin_hi,    // rate pin 1 output
	output logic            rate_pin_oe,    // rate pins driven when high
	output logic      [1:0] rate_pin_seen,  // rate pin levels seen
	output setup_cfg_t      cfg_out         // decoded setup
);

	////////////////////////////////////////////////////////////////
	logic [7:0] floppy_iface_setup_reg;
	logic [7:0] ext_port_setup_reg;
	logic       wr_floppy;
	logic       wr_ext;

	// index decode shared by read and write paths
	function automatic logic hit(input logic [7:0] idx, input logic [7:0] want, input logic mode);
		hit = mode && (idx == want);
	endfunction

	assign wr_floppy = wr_stb && hit(config_index_reg, IDX_FLOPPY_IFACE, config_mode);
	assign wr_ext    = wr_stb && hit(config_index_reg, IDX_EXT_PORT, config_mode);

	////////////////////////////////////////////////////////////////
	// floppy setup storage; reserved bit 0 never stored
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			floppy_iface_setup_reg <= RST_FLOPPY_IFACE;
		end else if (wr_floppy) begin
			floppy_iface_setup_reg <= wr_data & MASK_FLOPPY_IFACE;
		end
	end

	// extended setup storage; bit 7 forced low even if software sets it
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ext_port_setup_reg <= RST_EXT_PORT;
		end else if (wr_ext) begin
			ext_port_setup_reg <= wr_data & MASK_EXT_PORT;
		end
	end

	////////////////////////////////////////////////////////////////
	// read port; unmatched index or outside config mode returns zero
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_stb;
			if (rd_stb && hit(config_index_reg, IDX_FLOPPY_IFACE, config_mode)) begin
				rd_data <= floppy_iface_setup_reg & MASK_FLOPPY_IFACE;
			end else if (rd_stb && hit(config_index_reg, IDX_EXT_PORT, config_mode)) begin
				rd_data <= ext_port_setup_reg & MASK_EXT_PORT;
			end else if (rd_stb) begin
				rd_data <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// rate pin mapping; enhanced mode treats options as 00
	logic       opt0;
	logic       opt1;
	logic [1:0] rate_pins_next;
	logic       rate_oe_next;

	always_comb begin
		opt0 = floppy_iface_setup_reg[FI_OPT0] && !floppy_iface_setup_reg[FI_ENH_MODE];
		opt1 = floppy_iface_setup_reg[FI_OPT1] && !floppy_iface_setup_reg[FI_ENH_MODE];
		rate_pins_next = 2'b00;
		rate_oe_next   = 1'b1;
		// the 01 code is passed through as is; its real rate is set elsewhere
		case ({opt1, opt0})
			2'b00: rate_pins_next = rate_sel;
			2'b01: begin
				case (rate_sel)
					2'b11:   rate_pins_next = 2'b11;
					2'b00:   rate_pins_next = 2'b10;
					2'b01:   rate_pins_next = 2'b01;
					2'b10:   rate_pins_next = 2'b00;
					default: rate_pins_next = 2'b00;
				endcase
			end
			// undefined combination: pins held low, not to be relied on
			2'b10:   rate_pins_next = 2'b00;
			2'b11:   rate_oe_next = 1'b0;
			default: rate_oe_next = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rate_pin_lo   <= 1'b0;
			rate_pin_hi   <= 1'b0;
			rate_pin_oe   <= 1'b0;
			rate_pin_seen <= 2'b00;
		end else begin
			rate_pin_lo   <= rate_pins_next[0];
			rate_pin_hi   <= rate_pins_next[1];
			rate_pin_oe   <= rate_oe_next;
			rate_pin_seen <= rate_pin_in;
		end
	end

	////////////////////////////////////////////////////////////////
	// decoded configuration for neighbouring blocks
	setup_cfg_t cfg_next;

	always_comb begin
		cfg_next.enh_mode   = floppy_iface_setup_reg[FI_ENH_MODE];
		cfg_next.iface_mode = iface_mode_t'({floppy_iface_setup_reg[FI_IDENT],
			floppy_iface_setup_reg[FI_ENC]});
		cfg_next.pin_role   = pin_role_t'({floppy_iface_setup_reg[FI_PIN_SEL_H],
			floppy_iface_setup_reg[FI_PIN_SEL_L]});
		// printer mode overrides extended modes back to plain spp
		cfg_next.pp_mode    = printer_mode ? PP_SPP
			: pp_mode_t'(ext_port_setup_reg[EP_MODE_LO +: 2]);
		cfg_next.pport_fdc  = ext_port_setup_reg[EP_FDC_LO +: 2];
		cfg_next.uart_a_div = ext_port_setup_reg[EP_UART_A] ? DIV_MUSIC : DIV_NORMAL;
		cfg_next.uart_b_div = ext_port_setup_reg[EP_UART_B] ? DIV_MUSIC : DIV_NORMAL;
		cfg_next.epp_rev17  = ext_port_setup_reg[EP_EPP_TYPE];
		cfg_next.ecr_epp_ok = (cfg_next.pp_mode == PP_ECP_EPP);
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cfg_out <= '0;
		end else begin
			cfg_out <= cfg_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks on the read path; the index is looked at one edge back
	// because read data lags its strobe by a cycle
	reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
		(rd_valid && $past(config_index_reg) == IDX_FLOPPY_IFACE) |-> rd_data[0] == 1'b0)
		else $error("floppy reserved bit read as one");
	ext_read_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
		(rd_valid && $past(config_index_reg) == IDX_EXT_PORT) |-> rd_data[7] == 1'b0)
		else $error("extended reserved bit read as one");
	read_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
		rd_stb |=> rd_valid)
		else $error("read strobe gave no valid pulse");
	floppy_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		(rd_stb && config_mode && config_index_reg == IDX_FLOPPY_IFACE)
		|=> rd_data == ($past(floppy_iface_setup_reg) & 8'hFE))
		else $error("floppy register read wrong");
	ext_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		(rd_stb && config_mode && config_index_reg == IDX_EXT_PORT)
		|=> rd_data == ($past(ext_port_setup_reg) & 8'h7F))
		else $error("extended register read wrong");
	// a refused read must not leak the last register value
	read_refused_a: assert property (@(posedge clock) disable iff (!rst_n)
		(rd_stb && (!config_mode || (config_index_reg != IDX_FLOPPY_IFACE
			&& config_index_reg != IDX_EXT_PORT))) |=> rd_data == 8'h00)
		else $error("refused read returned data");

	// checks on storage; the reset check has no disable so it sees reset
	reset_values_a: assert property (@(posedge clock)
		!rst_n |=> floppy_iface_setup_reg == 8'h78 && ext_port_setup_reg == 8'h00)
		else $error("setup registers not at reset values");
	ext_bit7_a: assert property (@(posedge clock) disable iff (!rst_n)
		ext_port_setup_reg[7] == 1'b0)
		else $error("extended bit 7 stored");
	floppy_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_stb && config_mode && config_index_reg == IDX_FLOPPY_IFACE)
		|=> floppy_iface_setup_reg == ($past(wr_data) & 8'hFE))
		else $error("floppy register write lost");
	ext_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_stb && config_mode && config_index_reg == IDX_EXT_PORT)
		|=> ext_port_setup_reg == ($past(wr_data) & 8'h7F))
		else $error("extended register write lost");
	guarded_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		(!config_mode || config_index_reg != IDX_EXT_PORT) |=> $stable(ext_port_setup_reg))
		else $error("extended register changed without access");
	floppy_guard_a: assert property (@(posedge clock) disable iff (!rst_n)
		(!config_mode || config_index_reg != IDX_FLOPPY_IFACE)
		|=> $stable(floppy_iface_setup_reg))
		else $error("floppy register changed without access");

	// checks on the rate pins
	pins_input_a: assert property (@(posedge clock) disable iff (!rst_n)
		(floppy_iface_setup_reg[4:3] == 2'b11 && !floppy_iface_setup_reg[1]) |=> !rate_pin_oe)
		else $error("rate pins driven with options 11");
	// the far side sets the levels whenever the pins are released
	pin_sense_a: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> rate_pin_seen == $past(rate_pin_in))
		else $error("rate pin levels not sensed");
	enh_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
		floppy_iface_setup_reg[1] |=> rate_pin_oe)
		else $error("rate pins released in enhanced mode");
	copy_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
		(floppy_iface_setup_reg[1] || floppy_iface_setup_reg[4:3] == 2'b00)
		|=> rate_pin_oe && {rate_pin_hi, rate_pin_lo} == $past(rate_sel))
		else $error("rate pins do not copy select");
	remap_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
		(floppy_iface_setup_reg[4:3] == 2'b01 && !floppy_iface_setup_reg[1]
			&& rate_sel == 2'b00) |=> {rate_pin_hi, rate_pin_lo} == 2'b10)
		else $error("remapped 500 rate wrong");
	remap_250_a: assert property (@(posedge clock) disable iff (!rst_n)
		(floppy_iface_setup_reg[4:3] == 2'b01 && !floppy_iface_setup_reg[1]
			&& rate_sel == 2'b10) |=> {rate_pin_hi, rate_pin_lo} == 2'b00)
		else $error("remapped 250 rate wrong");
	remap_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
		(floppy_iface_setup_reg[4:3] == 2'b01 && !floppy_iface_setup_reg[1] && rate_sel[0])
		|=> rate_pin_oe && {rate_pin_hi, rate_pin_lo} == $past(rate_sel))
		else $error("remapped 1000 or 300 rate wrong");
	// the undefined option setting is still driven, low, so the pins never float
	rsvd_option_a: assert property (@(posedge clock) disable iff (!rst_n)
		(floppy_iface_setup_reg[4:3] == 2'b10 && !floppy_iface_setup_reg[1])
		|=> rate_pin_oe && {rate_pin_hi, rate_pin_lo} == 2'b00)
		else $error("undefined option setting not held low");

	// checks on the decoded setup; a write shows two edges later,
	// one for the register and one for the registered decode
	enh_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_stb && config_mode && config_index_reg == IDX_FLOPPY_IFACE)
		|-> ##2 cfg_out.enh_mode == $past(wr_data[1], 2))
		else $error("floppy mode not decoded");
	iface_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_stb && config_mode && config_index_reg == IDX_FLOPPY_IFACE)
		|-> ##2 cfg_out.iface_mode == $past(wr_data[6:5], 2))
		else $error("interface mode not decoded");
	pin_role_a: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_stb && config_mode && config_index_reg == IDX_FLOPPY_IFACE)
		|-> ##2 cfg_out.pin_role == {$past(wr_data[7], 2), $past(wr_data[2], 2)})
		else $error("shared pin role not decoded");
	port_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_stb && config_mode && config_index_reg == IDX_EXT_PORT) ##1 !printer_mode
		|=> cfg_out.pp_mode == $past(wr_data[1:0], 2))
		else $error("port mode not decoded");
	printer_spp_a: assert property (@(posedge clock) disable iff (!rst_n)
		printer_mode |=> cfg_out.pp_mode == PP_SPP)
		else $error("printer mode did not force spp");
	pport_route_a: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_stb && config_mode && config_index_reg == IDX_EXT_PORT)
		|-> ##2 cfg_out.pport_fdc == $past(wr_data[3:2], 2))
		else $error("floppy routing not decoded");
	epp_rev_a: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_stb && config_mode && config_index_reg == IDX_EXT_PORT)
		|-> ##2 cfg_out.epp_rev17 == $past(wr_data[6], 2))
		else $error("epp revision not decoded");
	// divisor values are fixed: 13 normally, 12 for the music rate
	uart_div_a: assert property (@(posedge clock) disable iff (!rst_n)
		ext_port_setup_reg[4] |=> cfg_out.uart_a_div == 4'hC)
		else $error("uart a divisor wrong");
	uart_a_norm_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ext_port_setup_reg[4] |=> cfg_out.uart_a_div == 4'hD)
		else $error("uart a normal divisor wrong");
	uart_b_div_a: assert property (@(posedge clock) disable iff (!rst_n)
		!ext_port_setup_reg[5] |=> cfg_out.uart_b_div == 4'hD)
		else $error("uart b divisor wrong");
	uart_b_music_a: assert property (@(posedge clock) disable iff (!rst_n)
		ext_port_setup_reg[5] |=> cfg_out.uart_b_div == 4'hC)
		else $error("uart b music divisor wrong");
	// the ecr code is only meaningful with both extended modes on
	ecr_epp_a: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_stb && config_mode && config_index_reg == IDX_EXT_PORT
			&& wr_data[1:0] == 2'b11) ##1 !printer_mode |=> cfg_out.ecr_epp_ok)
		else $error("ecr epp code not allowed");
	ecr_only_a: assert property (@(posedge clock) disable iff (!rst_n)
		cfg_out.ecr_epp_ok |-> cfg_out.pp_mode == PP_ECP_EPP)
		else $error("ecr epp code allowed outside ecp with epp");
endmodule
`default_nettype wire

// *** sim/rate_pin_far_end.sv ***
// far side of the two data-rate pins
`timescale 1ns/1ps
`default_nettype none
module rate_pin_far_end (
	input  wire logic       oe,   // device drives the pins
	input  wire logic [1:0] drv,  // device pin levels, hi then lo
	input  wire logic [1:0] ext,  // level the drive side applies
	output logic      [1:0] pins  // resolved pin levels
);
	// released pins show the drive side, never a stale device level
	assign pins = oe ? drv : ext;
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the floppy and port setup registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cfg_setup_pkg::*;
	logic       clock = 0, rst_n = 0, config_mode = 0, wr_stb = 0, rd_stb = 0;
	logic       printer_mode = 0, rd_valid, rate_pin_lo, rate_pin_hi, rate_pin_oe;
	logic [7:0] config_index_reg = 8'h00, wr_data = 8'h00, rd_data;
	logic [7:0] cfgv [3] = '{8'h60, 8'h68, 8'h7A};
	logic [1:0] rate_sel = 2'h0, ext = 2'h2, pins, rate_pin_seen, v, ex;
	setup_cfg_t cfg_out;
	int         miscompares = 0, n_compared = 0;

	fdc_pport_serial_setup_regs fdc_pport_serial_setup_regs_i (.clock(clock), .rst_n(rst_n),
		.config_mode(config_mode), .config_index_reg(config_index_reg), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .wr_data(wr_data), .printer_mode(printer_mode), .rate_sel(rate_sel),
		.rate_pin_in(pins), .rd_data(rd_data), .rd_valid(rd_valid), .rate_pin_lo(rate_pin_lo),
		.rate_pin_hi(rate_pin_hi), .rate_pin_oe(rate_pin_oe), .rate_pin_seen(rate_pin_seen),
		.cfg_out(cfg_out));
	rate_pin_far_end rate_pin_far_end_i (.oe(rate_pin_oe), .drv({rate_pin_hi, rate_pin_lo}),
		.ext(ext), .pins(pins));

	initial forever #2.5 clock = ~clock;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// every task starts and ends on a falling edge
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		config_index_reg = i;
		wr_data = d;
		wr_stb = 1'b1;
		@(negedge clock);
		wr_stb = 1'b0;
		// second edge lets the decoded outputs catch up
		repeat (2) @(negedge clock);
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		config_index_reg = i;
		rd_stb = 1'b1;
		@(negedge clock);
		rd_stb = 1'b0;
		chk("rd_valid", 8'h01, {7'h00, rd_valid});
		chk("rd_data", e, rd_data);
		@(negedge clock);
	endtask
	task automatic conclude;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// whole run is under a hundred cycles
	initial begin
		#20000;
		miscompares++;
		conclude();
	end
	initial begin
		repeat (8) @(negedge clock);
		rst_n = 1'b1;
		config_mode = 1'b1;
		@(negedge clock);
		rd(IDX_FLOPPY_IFACE, RST_FLOPPY_IFACE);
		rd(IDX_EXT_PORT, RST_EXT_PORT);
		chk("iface_mode", {6'h00, IF_AT}, {6'h00, cfg_out.iface_mode});
		chk("uart_a_div", {4'h0, DIV_NORMAL}, {4'h0, cfg_out.uart_a_div});
		chk("rate_pin_oe", 8'h00, {7'h00, rate_pin_oe});
		wr(IDX_FLOPPY_IFACE, 8'hFF);
		rd(IDX_FLOPPY_IFACE, 8'hFE);
		wr(IDX_EXT_PORT, 8'hFF);
		rd(IDX_EXT_PORT, 8'h7F);
		$display("test reset and reserved done");
		// options 00, option 0 only, enhanced mode with options 11
		foreach (cfgv[k]) begin
			wr(IDX_FLOPPY_IFACE, cfgv[k]);
			chk("enh_mode", {7'h00, k == 2}, {7'h00, cfg_out.enh_mode});
			for (int r = 0; r < 4; r++) begin
				rate_sel = 2'(r);
				@(negedge clock);
				ex = (k == 1) ? {~(rate_sel[1] ^ rate_sel[0]), rate_sel[0]} : rate_sel;
				chk("rate_pins", {6'h00, ex}, {6'h00, rate_pin_hi, rate_pin_lo});
				chk("rate_pin_oe", 8'h01, {7'h00, rate_pin_oe});
			end
		end
		// option 1 alone: undefined, but driven low
		wr(IDX_FLOPPY_IFACE, 8'h70);
		chk("rate_pin_oe", 8'h01, {7'h00, rate_pin_oe});
		chk("rate_pins", 8'h00, {6'h00, rate_pin_hi, rate_pin_lo});
		wr(IDX_FLOPPY_IFACE, 8'h78);
		ext = 2'h1;
		@(negedge clock);
		chk("rate_pin_oe", 8'h00, {7'h00, rate_pin_oe});
		chk("rate_pin_seen", 8'h01, {6'h00, rate_pin_seen});
		$display("test rate pins done");
		for (int i = 0; i < 4; i++) begin
			v = 2'(i);
			wr(IDX_FLOPPY_IFACE, {v[1], v, 2'b11, v[0], 2'b00});
			chk("iface_mode", {6'h00, v}, {6'h00, cfg_out.iface_mode});
			chk("pin_role", {6'h00, v}, {6'h00, cfg_out.pin_role});
			wr(IDX_EXT_PORT, {1'b0, v[0], v[1], v[0], v, v});
			chk("pp_mode", {6'h00, v}, {6'h00, cfg_out.pp_mode});
			chk("pport_fdc", {6'h00, v}, {6'h00, cfg_out.pport_fdc});
			chk("uart_a_div", v[0] ? 8'h0C : 8'h0D, {4'h0, cfg_out.uart_a_div});
			chk("uart_b_div", v[1] ? 8'h0C : 8'h0D, {4'h0, cfg_out.uart_b_div});
			chk("epp_rev17", {7'h00, v[0]}, {7'h00, cfg_out.epp_rev17});
			chk("ecr_epp_ok", {7'h00, v == 2'h3}, {7'h00, cfg_out.ecr_epp_ok});
		end
		printer_mode = 1'b1;
		@(negedge clock);
		chk("pp_mode", {6'h00, PP_SPP}, {6'h00, cfg_out.pp_mode});
		printer_mode = 1'b0;
		$display("test field decode done");
		wr(8'h05, 8'h00);
		rd(IDX_EXT_PORT, 8'h7F);
		config_mode = 1'b0;
		wr(IDX_EXT_PORT, 8'h00);
		rd(IDX_EXT_PORT, 8'h00);
		config_mode = 1'b1;
		rd(IDX_EXT_PORT, 8'h7F);
		$display("test refused access done");
		// mid-run reset brings both registers and the decode back
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		rd(IDX_FLOPPY_IFACE, RST_FLOPPY_IFACE);
		rd(IDX_EXT_PORT, RST_EXT_PORT);
		chk("pin_role", {6'h00, PIN_DRV_IN}, {6'h00, cfg_out.pin_role});
		chk("uart_a_div", {4'h0, DIV_NORMAL}, {4'h0, cfg_out.uart_a_div});
		$display("test mid-run reset done");
		conclude();
	end
endmodule
`default_nettype wire
